//--- rtl/edw_pkg.sv
// Purpose: shared constants for the extended dma write command link
// Assumes: one clock for both ends
// Notes: link register indices are 4-bit, host offsets are byte addresses
`default_nettype none
package edw_pkg;
    // ----------------------------------------
    // link register indices
    // ----------------------------------------
    localparam logic [3:0] LR_COUNT = 4'h1;
    localparam logic [3:0] LR_LBA_LOW = 4'h2;
    localparam logic [3:0] LR_LBA_MID = 4'h3;
    localparam logic [3:0] LR_LBA_HIGH = 4'h4;
    localparam logic [3:0] LR_UNIT = 4'h6;
    localparam logic [3:0] LR_OPCODE = 4'h7;
    localparam logic [3:0] LR_COND = 4'h7;
    localparam logic [3:0] LR_FAULT = 4'h8;
    localparam logic [7:0] OP_DMA_WRITE_EXT = 8'h35;
    localparam logic [7:0] UNIT_LBA_MODE = 8'h40;
    // ----------------------------------------
    // flag bit positions, default sector words
    // ----------------------------------------
    localparam int FB_CRC = 7;
    localparam int FB_IDNF = 4;
    localparam int FB_ABORT = 2;
    localparam int SB_BUSY = 7;
    localparam int SB_READY = 6;
    localparam int SB_SEEK = 4;
    localparam int SB_DRQ = 3;
    localparam int SB_ERR = 0;
    localparam int SECTOR_WORDS_DEF = 256;
    // ----------------------------------------
    // host register byte offsets, irq and status bit positions
    // ----------------------------------------
    localparam logic [5:0] HO_CTRL = 6'h00;
    localparam logic [5:0] HO_LBA_LO = 6'h04;
    localparam logic [5:0] HO_LBA_HI = 6'h08;
    localparam logic [5:0] HO_COUNT = 6'h0C;
    localparam logic [5:0] HO_STATUS = 6'h10;
    localparam logic [5:0] HO_FAIL_LO = 6'h14;
    localparam logic [5:0] HO_FAIL_HI = 6'h18;
    localparam logic [5:0] HO_IRQ_STAT = 6'h1C;
    localparam logic [5:0] HO_IRQ_MASK = 6'h20;
    localparam logic [5:0] HO_OPCODE = 6'h24;
    localparam int IB_DONE = 0;
    localparam int IB_ERR = 1;
    localparam int HS_BUSY = 16;
endpackage : edw_pkg
`default_nettype wire

//--- rtl/edw_link_if.sv
// Purpose: command block and dma wires between host adapter and device
// Assumes: both ends on ref_clk, every signal driven from a flop
// Notes: no clocking block
`default_nettype none
interface edw_link_if;
    logic reg_wr;
    logic reg_rd;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata;
    logic high_byte_select;
    logic [7:0] reg_rdata;
    logic dmarq;
    logic dmack;
    logic [15:0] dma_data;
    logic intrq;
    modport dev (input reg_wr, reg_rd, reg_addr, reg_wdata, high_byte_select, dmack,
        dma_data, output reg_rdata, dmarq, intrq);
    modport host (output reg_wr, reg_rd, reg_addr, reg_wdata, high_byte_select, dmack,
        dma_data, input reg_rdata, dmarq, intrq);
endinterface : edw_link_if
`default_nettype wire

//--- rtl/edw_host.sv
// Purpose: host adapter: loads the command block, feeds dma words, reads back status
// Assumes: avalon-mm slave with waitrequest, one wait state per access
// Notes: dma words come from a source that advances on src_ack
`default_nettype none
module edw_host import edw_pkg::*; (
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    // avalon-mm slave
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq,
    // word source
    input wire logic [15:0] src_data,
    input wire logic src_valid,
    output logic src_ack,
    // link
    edw_link_if.host link
);
    typedef enum logic [2:0] {H_IDLE, H_SETUP, H_RUN, H_READ} edw_hstate_e;
    edw_hstate_e state;
    logic [47:0] lba;
    logic [15:0] count;
    logic [7:0] opcode;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [7:0] cond_q;
    logic [7:0] fault_q;
    logic [47:0] fail_lba;
    logic [3:0] step;

    function automatic logic [3:0] setup_addr(input logic [3:0] s);
        if (s < 4'h2) setup_addr = LR_COUNT;
        else if (s < 4'h4) setup_addr = LR_LBA_LOW;
        else if (s < 4'h6) setup_addr = LR_LBA_MID;
        else if (s < 4'h8) setup_addr = LR_LBA_HIGH;
        else if (s == 4'h8) setup_addr = LR_UNIT;
        else setup_addr = LR_OPCODE;
    endfunction : setup_addr

    function automatic logic [3:0] read_addr(input logic [3:0] s);
        if (s == 4'h0) read_addr = LR_COND;
        else if (s == 4'h1) read_addr = LR_FAULT;
        else if (s == 4'h2 || s == 4'h5) read_addr = LR_LBA_LOW;
        else if (s == 4'h3 || s == 4'h6) read_addr = LR_LBA_MID;
        else read_addr = LR_LBA_HIGH;
    endfunction : read_addr

    // ----------------------------------------
    // decode
    // ----------------------------------------
    wire bus_req = (avs_read || avs_write) && avs_waitrequest;
    wire bus_wr = avs_write && !avs_waitrequest;
    wire go = bus_wr && avs_address == HO_CTRL && avs_writedata[0] && state == H_IDLE;
    // previous byte first, then current [RULE8] [RULE9] [RULE15]
    wire [7:0] setup_data = (step == 4'h0) ? count[15:8] :
        (step == 4'h1) ? count[7:0] :
        (step == 4'h2) ? lba[31:24] :
        (step == 4'h3) ? lba[7:0] :
        (step == 4'h4) ? lba[39:32] :
        (step == 4'h5) ? lba[15:8] :
        (step == 4'h6) ? lba[47:40] :
        (step == 4'h7) ? lba[23:16] :
        (step == 4'h8) ? UNIT_LBA_MODE : opcode;
    // take at most every other cycle so dmarq can drop after the last word [RULE5]
    wire take = state == H_RUN && link.dmarq && !link.dmack && !src_ack && src_valid;
    wire finished = state == H_READ && step == 4'h9;
    wire [1:0] irq_set = {finished && fault_q != 8'h00, finished};
    wire [1:0] irq_clr = (bus_wr && avs_address == HO_IRQ_STAT) ? avs_writedata[1:0] : 2'h0;
    wire [31:0] rd_mux = (avs_address == HO_CTRL) ? {31'h0, state != H_IDLE} :
        (avs_address == HO_LBA_LO) ? lba[31:0] :
        (avs_address == HO_LBA_HI) ? {16'h0, lba[47:32]} :
        (avs_address == HO_COUNT) ? {16'h0, count} :
        (avs_address == HO_STATUS) ? {15'h0, state != H_IDLE, fault_q, cond_q} :
        (avs_address == HO_FAIL_LO) ? fail_lba[31:0] :
        (avs_address == HO_FAIL_HI) ? {16'h0, fail_lba[47:32]} :
        (avs_address == HO_IRQ_STAT) ? {30'h0, irq_stat} :
        (avs_address == HO_IRQ_MASK) ? {30'h0, irq_mask} :
        (avs_address == HO_OPCODE) ? {24'h0, opcode} : 32'h0;

    // ----------------------------------------
    // avalon slave and software registers
    // ----------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0;
            lba <= 48'h0;
            count <= 16'h0;
            opcode <= OP_DMA_WRITE_EXT;
            irq_mask <= 2'h0;
            irq_stat <= 2'h0;
            irq <= 1'b0;
        end else if (ce) begin
            avs_waitrequest <= !bus_req;
            if (bus_req) avs_readdata <= rd_mux;
            if (bus_wr && avs_address == HO_LBA_LO) lba[31:0] <= avs_writedata;
            if (bus_wr && avs_address == HO_LBA_HI) lba[47:32] <= avs_writedata[15:0];
            if (bus_wr && avs_address == HO_COUNT) count <= avs_writedata[15:0];
            if (bus_wr && avs_address == HO_OPCODE) opcode <= avs_writedata[7:0];
            if (bus_wr && avs_address == HO_IRQ_MASK) irq_mask <= avs_writedata[1:0];
            // set beats a simultaneous clear
            irq_stat <= (irq_stat & ~irq_clr) | irq_set;
            irq <= |(((irq_stat & ~irq_clr) | irq_set) & irq_mask);
        end
    end

    // ----------------------------------------
    // command sequencer
    // ----------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state <= H_IDLE;
            step <= 4'h0;
            link.reg_wr <= 1'b0;
            link.reg_rd <= 1'b0;
            link.reg_addr <= 4'h0;
            link.reg_wdata <= 8'h0;
            link.high_byte_select <= 1'b0;
            link.dmack <= 1'b0;
            link.dma_data <= 16'h0;
            src_ack <= 1'b0;
            cond_q <= 8'h0;
            fault_q <= 8'h0;
            fail_lba <= 48'h0;
        end else if (ce) begin
            link.reg_wr <= 1'b0;
            link.reg_rd <= 1'b0;
            link.dmack <= take;
            src_ack <= take;
            if (take) link.dma_data <= src_data; // one word per ack [RULE3]
            case (state)
                H_IDLE: begin
                    step <= 4'h0;
                    if (go) state <= H_SETUP;
                end
                H_SETUP: begin
                    // dma path is armed only in H_RUN, entered on the same edge as the opcode write [RULE4]
                    link.reg_wr <= 1'b1;
                    link.reg_addr <= setup_addr(step);
                    link.reg_wdata <= setup_data;
                    link.high_byte_select <= 1'b0;
                    step <= step + 4'h1;
                    if (step == 4'h9) state <= H_RUN;
                end
                H_RUN: begin
                    step <= 4'h0;
                    if (link.intrq) state <= H_READ;
                end
                default: begin
                    // address flop plus reply flop: a read lands two steps after issue
                    if (step < 4'h8) begin
                        link.reg_rd <= 1'b1;
                        link.reg_addr <= read_addr(step);
                        link.high_byte_select <= step > 4'h4;
                    end
                    case (step)
                        4'h2: cond_q <= link.reg_rdata;
                        4'h3: fault_q <= link.reg_rdata;
                        4'h4: fail_lba[7:0] <= link.reg_rdata;
                        4'h5: fail_lba[15:8] <= link.reg_rdata;
                        4'h6: fail_lba[23:16] <= link.reg_rdata;
                        4'h7: fail_lba[31:24] <= link.reg_rdata;
                        4'h8: fail_lba[39:32] <= link.reg_rdata;
                        4'h9: fail_lba[47:40] <= link.reg_rdata;
                        default: ;
                    endcase
                    step <= step + 4'h1;
                    if (step == 4'h9) state <= H_IDLE;
                end
            endcase
        end
    end
endmodule : edw_host
`default_nettype wire

//--- rtl/edw_device.sv
// Purpose: device end of the extended dma write command
// Assumes: media side acknowledges each sector with commit_done
// Notes: registers written while busy are ignored
`default_nettype none
// Operation
// (RULE1) opcode 35h starts the extended dma write
// (RULE2) data only host to device, then committed
// (RULE3) sector payload moves as 16-bit words
// (RULE4) host arms dma before writing the opcode; edw_host arms it on the same edge as the opcode write
// (RULE5) words move only while dmarq is high
// (RULE6) one interrupt per command, after transfer ends
// (RULE7) uncorrectable error stops at the failing sector
// (RULE8) current count byte holds bits 7:0
// (RULE9) previous count byte holds bits 15:8
// (RULE10) zero count means 65536 sectors
// (RULE11) high select clear returns lba bits 23:0
// (RULE12) high select set returns lba bits 47:24
// (RULE13) error register reports only bits 7,4,2
// (RULE14) completion status: busy, fault, corrected clear
// (RULE15) host loads lba: current low, previous high
// (RULE16) failing address loaded only on error
module edw_device import edw_pkg::*; #(
    parameter int SECTOR_WORDS = SECTOR_WORDS_DEF
) (
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    // link
    edw_link_if.dev link,
    // media side
    output logic media_wr,
    output logic [15:0] media_data,
    output logic [47:0] media_lba,
    output logic sector_commit,
    input wire logic commit_done,
    input wire logic commit_fail,
    input wire logic crc_fail
);
    typedef enum logic [1:0] {D_IDLE, D_XFER, D_COMMIT} edw_dstate_e;
    edw_dstate_e state;
    logic [7:0] cnt_cur;
    logic [7:0] cnt_prev;
    logic [7:0] lba_cur [3];
    logic [7:0] lba_prev [3];
    logic [7:0] unit_sel;
    logic [16:0] sectors_left;
    logic [15:0] word_cnt;
    logic err_crc;
    logic err_idnf;
    logic err_abort;

    function automatic logic [7:0] fault_word(input logic c, input logic i, input logic a);
        fault_word = 8'h00;
        fault_word[FB_CRC] = c;
        fault_word[FB_IDNF] = i;
        fault_word[FB_ABORT] = a;
    endfunction : fault_word

    function automatic logic [7:0] cond_word(input logic b, input logic q, input logic e);
        cond_word = 8'h00;
        cond_word[SB_BUSY] = b;
        cond_word[SB_READY] = 1'b1;
        cond_word[SB_SEEK] = 1'b1;
        cond_word[SB_DRQ] = q;
        cond_word[SB_ERR] = e;
    endfunction : cond_word

    // ----------------------------------------
    // decode
    // ----------------------------------------
    wire busy = state != D_IDLE;
    wire wr_ok = link.reg_wr && !busy;
    wire [1:0] lba_idx = 2'(link.reg_addr - LR_LBA_LOW);
    wire is_lba = link.reg_addr >= LR_LBA_LOW && link.reg_addr <= LR_LBA_HIGH;
    wire opcode_wr = wr_ok && link.reg_addr == LR_OPCODE;
    wire start = opcode_wr && link.reg_wdata == OP_DMA_WRITE_EXT; // [RULE1]
    wire [15:0] count16 = {cnt_prev, cnt_cur}; // [RULE8] [RULE9]
    wire [16:0] first_count = (count16 == 16'h0) ? 17'h10000 : {1'b0, count16}; // [RULE10]
    wire last_word = word_cnt == 16'(SECTOR_WORDS - 1);
    wire word_in = state == D_XFER && link.dmack && link.dmarq; // [RULE5]
    wire fail_now = (word_in && crc_fail) || (state == D_COMMIT && commit_done && commit_fail);
    wire end_ok = state == D_COMMIT && commit_done && !commit_fail && sectors_left == 17'h1;
    wire any_err = err_crc || err_idnf || err_abort;
    // only the three reportable bits are ever set [RULE13]
    wire [7:0] fault_flags = fault_word(err_crc, err_idnf, err_abort);
    // busy, fault and corrected forced per completion; ready and seek held valid [RULE14]
    wire [7:0] condition_flags = cond_word(busy, link.dmarq, any_err);
    // high select picks the previous byte [RULE11] [RULE12]
    wire [7:0] rd_mux = (link.reg_addr == LR_COUNT) ?
            (link.high_byte_select ? cnt_prev : cnt_cur) :
        is_lba ? (link.high_byte_select ? lba_prev[lba_idx] : lba_cur[lba_idx]) :
        (link.reg_addr == LR_UNIT) ? unit_sel :
        (link.reg_addr == LR_COND) ? condition_flags :
        (link.reg_addr == LR_FAULT) ? fault_flags : 8'h00;

    // ----------------------------------------
    // command block registers
    // ----------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_cur <= 8'h0;
            cnt_prev <= 8'h0;
            lba_cur <= '{default: 8'h0};
            lba_prev <= '{default: 8'h0};
            unit_sel <= 8'h0;
            link.reg_rdata <= 8'h0;
        end else if (ce) begin
            link.reg_rdata <= rd_mux;
            // each count or lba write pushes the current byte into previous [RULE15]
            if (wr_ok && link.reg_addr == LR_COUNT) begin
                cnt_prev <= cnt_cur;
                cnt_cur <= link.reg_wdata;
            end
            if (wr_ok && is_lba) begin
                lba_prev[lba_idx] <= lba_cur[lba_idx];
                lba_cur[lba_idx] <= link.reg_wdata;
            end
            if (wr_ok && link.reg_addr == LR_UNIT) unit_sel <= link.reg_wdata;
            // failing address replaces the block only on error [RULE16] [RULE11] [RULE12]
            if (fail_now) begin
                lba_cur[0] <= media_lba[7:0];
                lba_cur[1] <= media_lba[15:8];
                lba_cur[2] <= media_lba[23:16];
                lba_prev[0] <= media_lba[31:24];
                lba_prev[1] <= media_lba[39:32];
                lba_prev[2] <= media_lba[47:40];
            end
        end
    end

    // ----------------------------------------
    // command engine
    // ----------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state <= D_IDLE;
            sectors_left <= 17'h0;
            word_cnt <= 16'h0;
            media_lba <= 48'h0;
            media_wr <= 1'b0;
            media_data <= 16'h0;
            sector_commit <= 1'b0;
            link.dmarq <= 1'b0;
            link.intrq <= 1'b0;
            err_crc <= 1'b0;
            err_idnf <= 1'b0;
            err_abort <= 1'b0;
        end else if (ce) begin
            media_wr <= word_in; // host to device only [RULE2]
            sector_commit <= 1'b0;
            // one interrupt per command; set wins over a status read
            if (fail_now || end_ok || (opcode_wr && !start)) link.intrq <= 1'b1; // [RULE6]
            else if (link.reg_rd && link.reg_addr == LR_COND) link.intrq <= 1'b0;
            case (state)
                D_IDLE: begin
                    if (opcode_wr) begin
                        // a refused opcode raises its interrupt at once
                        link.intrq <= !start;
                        err_crc <= 1'b0;
                        err_idnf <= 1'b0;
                        err_abort <= !start;
                    end
                    if (start) begin
                        state <= D_XFER;
                        sectors_left <= first_count;
                        word_cnt <= 16'h0;
                        media_lba <= {lba_prev[2], lba_prev[1], lba_prev[0],
                            lba_cur[2], lba_cur[1], lba_cur[0]};
                        link.dmarq <= 1'b1;
                    end
                end
                D_XFER: begin
                    if (word_in) begin
                        media_data <= link.dma_data; // [RULE3]
                        word_cnt <= word_cnt + 16'h1;
                        if (crc_fail) begin
                            err_crc <= 1'b1;
                            link.dmarq <= 1'b0;
                            state <= D_IDLE;
                        end else if (last_word) begin
                            link.dmarq <= 1'b0;
                            sector_commit <= 1'b1; // [RULE2]
                            state <= D_COMMIT;
                        end
                    end
                end
                default: begin
                    if (commit_done) begin
                        word_cnt <= 16'h0;
                        if (commit_fail) begin
                            // remaining sectors dropped [RULE7]
                            err_idnf <= 1'b1;
                            state <= D_IDLE;
                        end else if (sectors_left == 17'h1) begin
                            state <= D_IDLE;
                        end else begin
                            sectors_left <= sectors_left - 17'h1;
                            media_lba <= media_lba + 48'h1;
                            link.dmarq <= 1'b1;
                            state <= D_XFER;
                        end
                    end
                end
            endcase
        end
    end
endmodule : edw_device
`default_nettype wire

//--- verification/edw_asserts.sv
// Purpose: link checks for the extended dma write command
// Assumes: both ends on ref_clk, rst async high
// Notes: helper state follows one command at a time
`default_nettype none
module edw_asserts import edw_pkg::*; #(
    parameter int SECTOR_WORDS = SECTOR_WORDS_DEF
) (
    // clock, reset
    input wire logic ref_clk,
    input wire logic rst,
    // link
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic high_byte_select,
    input wire logic [7:0] reg_rdata,
    input wire logic dmarq,
    input wire logic dmack,
    input wire logic [15:0] dma_data,
    input wire logic intrq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic active;
    logic [15:0] word_cnt;
    wire logic op_wr = reg_wr && reg_addr == LR_OPCODE && !active;
    // active from opcode until the interrupt; word count restarts per sector
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            active <= 1'b0;
            word_cnt <= 16'h0000;
        end else begin
            active <= op_wr | (active & ~intrq);
            word_cnt <= intrq ? 16'h0000 : !dmack ? word_cnt :
                (word_cnt == 16'(SECTOR_WORDS - 1)) ? 16'h0000 : word_cnt + 16'h0001;
        end
    end
    sequence s_last_word;
        dmack && word_cnt == 16'(SECTOR_WORDS - 1);
    endsequence
    property p_start; op_wr && reg_wdata == OP_DMA_WRITE_EXT |=> dmarq; endproperty
    a_start: assert property (p_start) else $error("no request after opcode");
    property p_bad_op; op_wr && reg_wdata != OP_DMA_WRITE_EXT |=> intrq && !dmarq; endproperty
    a_bad_op: assert property (p_bad_op) else $error("bad opcode not ended");
    property p_dir; dmarq |-> active; endproperty
    a_dir: assert property (p_dir) else $error("request outside command");
    property p_sector_end; s_last_word |=> !dmarq; endproperty
    a_sector_end: assert property (p_sector_end) else $error("request past sector");
    property p_qualified; dmack |-> dmarq; endproperty
    a_qualified: assert property (p_qualified) else $error("word without request");
    property p_one_irq; $rose(intrq) |-> active; endproperty
    a_one_irq: assert property (p_one_irq) else $error("extra interrupt");
    property p_irq_after; intrq |-> !dmarq ##1 !dmarq; endproperty
    a_irq_after: assert property (p_irq_after) else $error("interrupt during transfer");
    property p_fault_bits; reg_addr == LR_FAULT |=> (reg_rdata & 8'h6B) == 8'h00; endproperty
    a_fault_bits: assert property (p_fault_bits) else $error("reserved fault bit set");
    property p_done_status;
        reg_addr == LR_COND && intrq && !high_byte_select |=> (reg_rdata & 8'hF4) == 8'h50;
    endproperty
    a_done_status: assert property (p_done_status) else $error("bad end status");
endmodule : edw_asserts
`default_nettype wire

//--- verification/ext_dma_write_command_test.sv
// Purpose: end-to-end bench for the extended dma write command
// Assumes: sectors of 4 words, media answered by the bench
// Notes: software reaches the command only through the avalon side
`default_nettype none
module ext_dma_write_command_test import edw_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SW = 4;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [5:0] avs_address = 6'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, irq, src_ack, media_wr, sector_commit, irq_on;
    logic [15:0] src_data = 16'h0000;
    logic src_valid = 1'b0;
    logic [15:0] media_data;
    logic [47:0] media_lba, lba_exp;
    logic commit_done = 1'b0;
    logic commit_fail = 1'b0;
    logic crc_fail = 1'b0;
    logic [15:0] src_q[$];
    logic [15:0] exp_q[$];
    logic [31:0] rd_q;
    int err_total = 0;
    int samples_checked = 0;
    int sect_n = 0;
    int fail_at = -1;
    int done_wait = 0;
    always #5 ref_clk = ~ref_clk;
    edw_link_if link ();
    edw_host edw_host_inst (.ref_clk(ref_clk), .rst(rst), .ce(1'b1),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq(irq), .src_data(src_data),
        .src_valid(src_valid), .src_ack(src_ack), .link(link));
    edw_device #(.SECTOR_WORDS(SW)) edw_device_inst (.ref_clk(ref_clk), .rst(rst), .ce(1'b1),
        .link(link), .media_wr(media_wr), .media_data(media_data), .media_lba(media_lba),
        .sector_commit(sector_commit), .commit_done(commit_done), .commit_fail(commit_fail),
        .crc_fail(crc_fail));
    edw_asserts #(.SECTOR_WORDS(SW)) edw_asserts_inst (.ref_clk(ref_clk), .rst(rst),
        .reg_wr(link.reg_wr), .reg_rd(link.reg_rd), .reg_addr(link.reg_addr),
        .reg_wdata(link.reg_wdata), .high_byte_select(link.high_byte_select),
        .reg_rdata(link.reg_rdata), .dmarq(link.dmarq), .dmack(link.dmack),
        .dma_data(link.dma_data), .intrq(link.intrq));
    // ----------------------------------------
    // word source and media model
    // ----------------------------------------
    always @(posedge ref_clk) begin
        if (src_ack && src_q.size() > 0)
            src_q.delete(0);
        src_valid <= src_q.size() > 0;
        src_data <= (src_q.size() > 0) ? src_q[0] : ~src_data;
        commit_done <= done_wait == 1;
        commit_fail <= done_wait == 1 && sect_n == fail_at;
        if (done_wait == 1)
            sect_n++;
        if (done_wait > 0)
            done_wait--;
        // slow media: commit answer comes 2 to 5 cycles late
        if (sector_commit)
            done_wait = 2 + $urandom_range(3);
        if (media_wr) begin
            check(media_data, exp_q.size() > 0 ? exp_q.pop_front() : ~media_data);
            check(media_lba, lba_exp + 48'(sect_n));
        end
    end
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic av(input logic wr, input logic [5:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do begin
            @(posedge ref_clk);
        end while (avs_waitrequest !== 1'b0);
        rd_q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge ref_clk);
    endtask : av
    task automatic run(input logic [47:0] lba, input int cnt, input int fa, input logic crc,
            input int nsec, input logic [7:0] flt);
        logic [47:0] fl;
        src_q.delete();
        for (int i = 0; i < nsec * SW; i++)
            src_q.push_back(16'($urandom));
        exp_q = src_q;
        lba_exp = lba;
        sect_n = 0;
        fail_at = fa;
        crc_fail <= crc;
        fl = lba + 48'((fa > 0) ? fa : 0);
        av(1'b1, HO_LBA_LO, lba[31:0]);
        av(1'b1, HO_LBA_HI, {16'h0000, lba[47:32]});
        av(1'b1, HO_COUNT, 32'(cnt));
        av(1'b1, HO_CTRL, 32'h1);
        do begin
            av(1'b0, HO_IRQ_STAT, 32'h0);
        end while (rd_q[IB_DONE] !== 1'b1);
        check(rd_q[1:0], {flt != 8'h00, 1'b1}); // done and error events
        av(1'b0, HO_STATUS, 32'h0);
        check(rd_q & 32'h1FFF5, {16'h0000, flt, 8'h50 | {7'h00, flt != 8'h00}});
        av(1'b0, HO_FAIL_LO, 32'h0);
        check(rd_q, fl[31:0]); // low address bytes
        av(1'b0, HO_FAIL_HI, 32'h0);
        check(rd_q[15:0], fl[47:32]); // high address bytes
        if (!crc)
            check(48'(sect_n), 48'(nsec)); // sectors written
        av(1'b1, HO_IRQ_MASK, 32'h3);
        repeat (2) @(posedge ref_clk);
        irq_on = irq;
        av(1'b1, HO_IRQ_MASK, 32'h0);
        repeat (2) @(posedge ref_clk);
        check({irq_on, irq}, 2'b10); // mask gates the line
        av(1'b1, HO_IRQ_STAT, 32'h3);
        av(1'b0, HO_IRQ_STAT, 32'h0);
        check(rd_q[1:0], 2'b00); // write one clears
        crc_fail <= 1'b0;
    endtask : run
    initial begin
        void'($urandom(71));
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        av(1'b0, HO_OPCODE, 32'h0);
        check(rd_q[7:0], OP_DMA_WRITE_EXT); // opcode reset value
        av(1'b0, 6'h28, 32'h0);
        check(rd_q, 32'h0); // unmapped offset
        run(48'({$urandom, $urandom}), 2, -1, 1'b0, 2, 8'h00);
        run(48'({$urandom, $urandom}), 257, 1, 1'b0, 2, 8'h10); // count above one byte
        run(48'({$urandom, $urandom}), 0, 2, 1'b0, 3, 8'h10); // zero count
        run(48'({$urandom, $urandom}), 1, -1, 1'b1, 1, 8'h80); // link crc abort
        av(1'b1, HO_OPCODE, 32'h25);
        run(48'({$urandom, $urandom}), 1, -1, 1'b0, 0, 8'h04); // foreign opcode
        av(1'b1, HO_OPCODE, 32'h35);
        final_report();
    end
    initial begin
        #400000;
        err_total++;
        final_report();
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : final_report
endmodule : ext_dma_write_command_test
`default_nettype wire
